/* File: pkg/ssp_pkg.sv */
// shared constants, field layout and helpers of the serial port control block
package ssp_pkg;

	// ==========================================
	// register map (word index on the plain port)
	localparam logic [3:0] ADDR_CTRL = 4'h0; // serial_port_control
	localparam logic [3:0] ADDR_DATA = 4'h1; // serial_data_buffer
	localparam logic [3:0] ADDR_STAT = 4'h2; // sticky event status, write one to clear
	localparam logic [3:0] ADDR_MASK = 4'h3; // interrupt mask, same layout as status

	// ==========================================
	// control field positions and reset values
	localparam int         BIT_OVF    = 6;     // receive_overflow_flag
	localparam int         BIT_EN     = 5;     // port_enable_bit
	localparam int         BIT_CKP    = 4;     // clock_polarity_bit
	localparam logic [3:0] MODE_RESET = 4'h0;  // port_mode_select_field after reset
	localparam logic [7:0] DATA_RESET = 8'h00; // buffer and shifter contents after reset

	// ==========================================
	// status and mask bits
	localparam int         ST_RX    = 0;    // a byte completed
	localparam int         ST_OVF   = 1;    // a byte was lost to overflow
	localparam int         ST_W     = 2;    // width of status and mask
	localparam logic [1:0] ST_RESET = 2'h0;

	// ==========================================
	// port_mode_select_field encodings
	localparam logic [3:0] MODE_M_DIV4  = 4'h0; // spi master, fastest clock
	localparam logic [3:0] MODE_M_DIV16 = 4'h1; // spi master
	localparam logic [3:0] MODE_M_DIV64 = 4'h2; // spi master
	localparam logic [3:0] MODE_M_SLOW  = 4'h3; // spi master, slowest clock
	localparam logic [3:0] MODE_S_SS    = 4'h4; // spi slave, select pin in use
	localparam logic [3:0] MODE_S_NOSS  = 4'h5; // spi slave, select pin ignored
	localparam logic [3:0] MODE_I_7     = 4'h6; // i2c slave, 7-bit address
	localparam logic [3:0] MODE_I_10    = 4'h7; // i2c slave, 10-bit address
	localparam logic [3:0] MODE_I_FW    = 4'hb; // i2c, firmware controlled
	localparam logic [3:0] MODE_I_7S    = 4'he; // i2c slave, 7-bit, start/stop events
	localparam logic [3:0] MODE_I_10S   = 4'hf; // i2c slave, 10-bit, start/stop events

	// ==========================================
	// timing: master half period of the serial clock, in host cycles
	localparam logic [7:0] HALF_DIV4  = 8'h02;
	localparam logic [7:0] HALF_DIV16 = 8'h08;
	localparam logic [7:0] HALF_DIV64 = 8'h20;
	localparam logic [7:0] HALF_SLOW  = 8'h80;
	localparam logic [3:0] BYTE_LAST  = 4'h7; // bit index of the eighth bit
	localparam logic [4:0] EDGE_LAST  = 5'hf; // sixteen clock edges per byte

	// ==========================================
	// mode decoding used by several processes
	function automatic logic is_master(input logic [3:0] m);
		is_master = (m[3:2] == 2'b00);
	endfunction : is_master

	function automatic logic is_slave(input logic [3:0] m);
		is_slave = (m == MODE_S_SS) || (m == MODE_S_NOSS);
	endfunction : is_slave

	function automatic logic is_spi(input logic [3:0] m);
		is_spi = is_master(m) || is_slave(m);
	endfunction : is_spi

	function automatic logic is_i2c(input logic [3:0] m);
		is_i2c = (m == MODE_I_7) || (m == MODE_I_10) || (m == MODE_I_FW) ||
			(m == MODE_I_7S) || (m == MODE_I_10S);
	endfunction : is_i2c

	// reload value of the master divider, one less than the half period
	function automatic logic [7:0] half_reload(input logic [3:0] m);
		case (m[1:0])
			2'b00:   half_reload = HALF_DIV4 - 8'h01;
			2'b01:   half_reload = HALF_DIV16 - 8'h01;
			2'b10:   half_reload = HALF_DIV64 - 8'h01;
			default: half_reload = HALF_SLOW - 8'h01;
		endcase
	endfunction : half_reload

endpackage : ssp_pkg

/* File: pkg/ssp_shift_if.sv */
// link between the port control and its bit shifter
`timescale 1ns/1ps
interface ssp_shift_if;
	logic       load;      // take load_data into the transmit shifter
	logic [7:0] load_data; // byte to send
	logic       tx_edge;   // drive next transmit bit
	logic       rx_edge;   // sample rx_bit
	logic       rx_bit;    // synchronised serial data in
	logic       clear;     // abort and restart the byte
	logic       sdo;       // current transmit bit
	logic       done;      // one-cycle pulse, eighth bit taken
	logic [7:0] rx_data;   // received byte, valid with done

	modport ctrl    (output load, load_data, tx_edge, rx_edge, rx_bit, clear,
	                 input  sdo, done, rx_data);
	modport shifter (input  load, load_data, tx_edge, rx_edge, rx_bit, clear,
	                 output sdo, done, rx_data);
endinterface : ssp_shift_if

/* File: verilog/ssp_shifter.sv */
// eight-bit transmit and receive shifter driven by edge pulses
`timescale 1ns/1ps
module ssp_shifter
	import ssp_pkg::*;
(
	// clock and reset
	input wire logic   clk,
	input wire logic   arst_n,
	// control side
	ssp_shift_if.shifter sh
);

	// ==========================================
	// state
	logic [7:0] tx_q, tx_d;   // transmit shifter, msb on the pin
	logic [7:0] rx_q, rx_d;   // serial_shift_register, receive side
	logic [3:0] cnt_q, cnt_d; // bits sampled in this byte
	logic       done_q, done_d;

	// next values: clear beats load beats shifting
	always_comb begin
		tx_d   = tx_q;
		rx_d   = rx_q;
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (sh.clear) begin
			// abort: bit count back to the start of a byte
			cnt_d = 4'h0;
			rx_d  = DATA_RESET;
		end else if (sh.load) begin
			tx_d  = sh.load_data;
			cnt_d = 4'h0;
		end else begin
			// the first leading edge presents the msb already on the pin
			if (sh.tx_edge && (cnt_q != 4'h0)) begin
				tx_d = {tx_q[6:0], 1'b0};
			end
			if (sh.rx_edge) begin
				rx_d = {rx_q[6:0], sh.rx_bit};
				if (cnt_q == BYTE_LAST) begin
					cnt_d  = 4'h0;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 4'h1;
				end
			end
		end
	end

	// register only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_q   <= DATA_RESET;
			rx_q   <= DATA_RESET;
			cnt_q  <= 4'h0;
			done_q <= 1'b0;
		end else begin
			tx_q   <= tx_d;
			rx_q   <= rx_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign sh.sdo     = tx_q[7];
	assign sh.done    = done_q;
	assign sh.rx_data = rx_q;

	// ==========================================
	// checks
	byte_done_a: assert property (@(posedge clk) disable iff (!arst_n)
		(sh.rx_edge && !sh.clear && !sh.load && cnt_q == BYTE_LAST) |=> (done_q && rx_q[0] == $past(sh.rx_bit)))
		else $error("byte completion not flagged after eighth bit");

endmodule : ssp_shifter

/* File: verilog/ssp_ctrl.sv */
// synchronous serial port control: register port, spi master/slave, i2c clock hold
`timescale 1ns/1ps
module ssp_ctrl
	import ssp_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// spi pins
	input  wire logic       sck_i,
	output logic            sck_o,
	output logic            sck_oe,
	input  wire logic       sdi_i,
	output logic            sdo_o,
	output logic            sdo_oe,
	input  wire logic       ss_n_i,
	// i2c clock pin, open drain
	output logic            scl_o,
	output logic            scl_oe,
	// pin ownership and interrupt
	output logic            spi_pins_own,
	output logic            i2c_pins_own,
	output logic            irq
);

	// ==========================================
	// master state machine type
	typedef enum logic [1:0] {
		SSP_M_IDLE = 2'b01, // clock parked at idle level
		SSP_M_RUN  = 2'b10  // sixteen half periods in flight
	} ssp_ms_t;

	// ==========================================
	// pin synchronisers
	logic [2:0] sck_s; // third stage only for edge detection
	logic [1:0] sdi_s;
	logic [1:0] ss_s;

	// plain two-stage capture, stage zero read by stage one only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_s <= 3'h0;
			sdi_s <= 2'h0;
			ss_s  <= 2'h3;
		end else begin
			sck_s <= {sck_s[1:0], sck_i};
			sdi_s <= {sdi_s[0], sdi_i};
			ss_s  <= {ss_s[0], ss_n_i};
		end
	end

	// ==========================================
	// registers of the control group
	logic            ovf_q, ovf_d;     // receive_overflow_flag
	logic            en_q, en_d;       // port_enable_bit
	logic            ckp_q, ckp_d;     // clock_polarity_bit
	logic [3:0]      mode_q, mode_d;   // port_mode_select_field
	logic [7:0]      buf_q, buf_d;     // serial_data_buffer
	logic            full_q, full_d;   // buffer holds an unread byte
	logic [ST_W-1:0] stat_q, stat_d;   // sticky events
	logic [ST_W-1:0] mask_q, mask_d;   // interrupt mask
	logic [7:0]      rdata_q, rdata_d; // read answer
	logic            irq_q, irq_d;

	// ==========================================
	// master clock generator state
	ssp_ms_t    ms_q, ms_d;
	logic [7:0] div_q, div_d;     // half period countdown
	logic [4:0] edge_q, edge_d;   // half periods done in this byte
	logic       mclk_q, mclk_d;   // internal master clock level
	logic       m_tx, m_rx;       // master edge pulses
	logic       start;            // software starts a master byte

	// ==========================================
	// pin output flops
	logic spi_own_q, spi_own_d;
	logic i2c_own_q, i2c_own_d;
	logic sck_o_q, sck_oe_q, sck_oe_d;
	logic sdo_o_q, sdo_oe_q, sdo_oe_d;
	logic scl_oe_q, scl_oe_d;
	logic scl_o_q;

	// ==========================================
	// decoded conditions
	logic master_on, slave_on, ss_ctl, ss_high;
	logic s_rise, s_fall, s_tx, s_rx;

	assign master_on = en_q && is_master(mode_q);
	assign slave_on  = en_q && is_slave(mode_q);
	assign ss_ctl    = (mode_q == MODE_S_SS);
	assign ss_high   = ss_s[1];
	// edge detectors look at stages one and two only
	assign s_rise    = sck_s[1] && !sck_s[2];
	assign s_fall    = !sck_s[1] && sck_s[2];
	assign s_tx      = ckp_q ? s_fall : s_rise;
	assign s_rx      = ckp_q ? s_rise : s_fall;
	assign start     = wr && (addr == ADDR_DATA) && master_on && (ms_q == SSP_M_IDLE);

	// ==========================================
	// shifter
	ssp_shift_if sh ();

	// edge pulses come from whichever end makes the clock
	always_comb begin
		sh.load      = wr && (addr == ADDR_DATA) && (start || slave_on);
		sh.load_data = wdata;
		sh.tx_edge   = master_on ? m_tx : (slave_on && s_tx);
		sh.rx_edge   = master_on ? m_rx : (slave_on && s_rx && !(ss_ctl && ss_high));
		sh.rx_bit    = sdi_s[1];
		sh.clear     = !en_q || (slave_on && ss_ctl && ss_high);
	end

	ssp_shifter u_shift (
		.clk    (clk),
		.arst_n (arst_n),
		.sh     (sh)
	);

	// ==========================================
	// register group next values
	always_comb begin
		ovf_d   = ovf_q;
		en_d    = en_q;
		ckp_d   = ckp_q;
		mode_d  = mode_q;
		buf_d   = buf_q;
		full_d  = full_q;
		stat_d  = stat_q;
		mask_d  = mask_q;
		rdata_d = 8'h00;
		// software writes first, hardware sets after so sets win
		if (wr) begin
			case (addr)
				ADDR_CTRL: begin
					// overflow is only cleared by software, never set
					ovf_d  = ovf_q && wdata[BIT_OVF];
					en_d   = wdata[BIT_EN];
					ckp_d  = wdata[BIT_CKP];
					mode_d = wdata[3:0];
				end
				ADDR_STAT: stat_d = stat_q & ~wdata[ST_W-1:0];
				ADDR_MASK: mask_d = wdata[ST_W-1:0];
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				ADDR_CTRL: rdata_d = {1'b0, ovf_q, en_q, ckp_q, mode_q};
				ADDR_DATA: begin
					rdata_d = buf_q;
					// reading the buffer frees it
					full_d  = 1'b0;
				end
				ADDR_STAT: rdata_d = {6'h00, stat_q};
				ADDR_MASK: rdata_d = {6'h00, mask_q};
				default:   rdata_d = 8'h00;
			endcase
		end
		if (sh.done) begin
			stat_d[ST_RX] = 1'b1;
			if (full_q && is_slave(mode_q)) begin
				ovf_d          = 1'b1;
				stat_d[ST_OVF] = 1'b1;
			end else begin
				// a master simply overwrites, the unread byte is gone
				buf_d  = sh.rx_data;
				full_d = 1'b1;
			end
		end
		irq_d = |(stat_d & mask_d);
	end

	// register group flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_q   <= 1'b0;
			en_q    <= 1'b0;
			ckp_q   <= 1'b0;
			mode_q  <= MODE_RESET;
			buf_q   <= DATA_RESET;
			full_q  <= 1'b0;
			stat_q  <= ST_RESET;
			mask_q  <= ST_RESET;
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
		end else begin
			ovf_q   <= ovf_d;
			en_q    <= en_d;
			ckp_q   <= ckp_d;
			mode_q  <= mode_d;
			buf_q   <= buf_d;
			full_q  <= full_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	// ==========================================
	// master clock next values
	always_comb begin
		ms_d   = ms_q;
		div_d  = div_q;
		edge_d = edge_q;
		mclk_d = mclk_q;
		m_tx   = 1'b0;
		m_rx   = 1'b0;
		case (ms_q)
			SSP_M_IDLE: begin
				mclk_d = ckp_d;
				edge_d = 5'h00;
				if (start) begin
					ms_d  = SSP_M_RUN;
					div_d = half_reload(mode_q);
				end
			end
			SSP_M_RUN: begin
				if (!master_on) begin
					// disabling mid-byte parks the clock at once
					ms_d   = SSP_M_IDLE;
					mclk_d = ckp_d;
				end else if (div_q == 8'h00) begin
					div_d  = half_reload(mode_q);
					mclk_d = !mclk_q;
					m_tx   = (mclk_q == ckp_q);
					m_rx   = (mclk_q != ckp_q);
					edge_d = edge_q + 5'h01;
					if (edge_q == EDGE_LAST) begin
						ms_d = SSP_M_IDLE;
					end
				end else begin
					div_d = div_q - 8'h01;
				end
			end
			default: begin
				ms_d   = SSP_M_IDLE;
				mclk_d = ckp_d;
			end
		endcase
	end

	// master clock flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_q   <= SSP_M_IDLE;
			div_q  <= 8'h00;
			edge_q <= 5'h00;
			mclk_q <= 1'b0;
		end else begin
			ms_q   <= ms_d;
			div_q  <= div_d;
			edge_q <= edge_d;
			mclk_q <= mclk_d;
		end
	end

	// ==========================================
	// pin output next values
	always_comb begin
		spi_own_d = en_d && is_spi(mode_d);
		i2c_own_d = en_d && is_i2c(mode_d);
		// clock enable only in master modes, a slave takes the clock from the pin
		sck_oe_d  = spi_own_d && is_master(mode_d);
		// a deselected slave leaves the data line to others
		sdo_oe_d  = spi_own_d && !is_master(mode_d) ? !((mode_d == MODE_S_SS) && ss_s[1]) : spi_own_d;
		// polarity zero stretches the i2c clock
		scl_oe_d  = i2c_own_d && !ckp_d;
	end

	// pin output flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			spi_own_q <= 1'b0;
			i2c_own_q <= 1'b0;
			sck_o_q   <= 1'b0;
			sck_oe_q  <= 1'b0;
			sdo_o_q   <= 1'b0;
			sdo_oe_q  <= 1'b0;
			scl_oe_q  <= 1'b0;
			scl_o_q   <= 1'b0;
		end else begin
			spi_own_q <= spi_own_d;
			i2c_own_q <= i2c_own_d;
			sck_o_q   <= mclk_d;
			sck_oe_q  <= sck_oe_d;
			sdo_o_q   <= sh.sdo;
			sdo_oe_q  <= sdo_oe_d;
			scl_oe_q  <= scl_oe_d;
			// open drain: the line is only ever pulled low
			scl_o_q   <= 1'b0;
		end
	end

	assign rdata        = rdata_q;
	assign sck_o        = sck_o_q;
	assign sck_oe       = sck_oe_q;
	assign sdo_o        = sdo_o_q;
	assign sdo_oe       = sdo_oe_q;
	assign scl_o        = scl_o_q;
	assign scl_oe       = scl_oe_q;
	assign spi_pins_own = spi_own_q;
	assign i2c_pins_own = i2c_own_q;
	assign irq          = irq_q;

	// ==========================================
	// checks
	spi_pin_own_a: assert property (@(posedge clk) disable iff (!arst_n)
		(en_q && is_spi(mode_q) && !wr) |=> (spi_pins_own && !i2c_pins_own))
		else $error("enabled spi port does not own its pins");

	i2c_pin_own_a: assert property (@(posedge clk) disable iff (!arst_n)
		!wr |=> (i2c_pins_own == $past(en_q && is_i2c(mode_q))))
		else $error("i2c pin ownership does not follow enable");

	slave_pol1_a: assert property (@(posedge clk) disable iff (!arst_n)
		(slave_on && ckp_q && s_fall) |-> (sh.tx_edge && !sh.rx_edge))
		else $error("polarity one slave not transmitting on falling edge");

	idle_clock_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ms_q == SSP_M_IDLE && !wr) ##1 (ms_q == SSP_M_IDLE) |-> (sck_o == ckp_q))
		else $error("idle serial clock not at polarity level");

	slave_pol0_a: assert property (@(posedge clk) disable iff (!arst_n)
		(slave_on && !ckp_q && s_rise) |-> (sh.tx_edge && !sh.rx_edge))
		else $error("polarity zero slave not transmitting on rising edge");

	scl_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		(en_q && is_i2c(mode_q) && !wr) |=> (scl_oe == !$past(ckp_q) && scl_o == 1'b0))
		else $error("i2c clock hold does not follow polarity");

	ovf_slave_a: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(ovf_q) |-> ($past(is_slave(mode_q)) && $past(full_q) && $stable(buf_q)))
		else $error("overflow set outside slave overflow case");

	ss_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
		(slave_on && ss_ctl && ss_high) |-> (sh.clear && !sh.rx_edge))
		else $error("select high did not reset slave logic");

	master_len_a: assert property (@(posedge clk) disable iff (!arst_n)
		(start && mode_q == MODE_M_DIV4 && ms_q == SSP_M_IDLE) ##1 (master_on && mode_q == MODE_M_DIV4)[*8]
		|-> (ms_q == SSP_M_RUN))
		else $error("master byte ended early");

endmodule : ssp_ctrl

/* File: testbench/ssp_spi_peer.sv */
// far end of the spi link: slave to the port as master, master to it as slave
`timescale 1ns/1ps
module ssp_spi_peer (
	// resolved link lines
	input  wire logic sck_w,
	input  wire logic sdo_w,
	// lines this model drives
	output logic      sck_m,
	output logic      sdi_m,
	output logic      ss_n_m
);
	logic       armed; // answering a byte from the port
	logic       pol;   // idle clock level in use
	logic [7:0] ptx;   // byte sent back
	logic [7:0] prx;   // byte taken from the port
	int         nedge; // trailing edges seen so far

	// quiet link at time zero
	initial begin
		armed  = 1'b0;
		sck_m  = 1'b0;
		sdi_m  = 1'b0;
		ss_n_m = 1'b1;
		prx    = 8'h00;
	end

	// ==========================================
	// slave role
	task automatic arm(input logic [7:0] b, input logic p);
		ptx   = b;
		pol   = p;
		nedge = 0;
		sdi_m = b[7];
		armed = 1'b1;
	endtask : arm

	// take on trailing edge, shift on leading
	always @(sck_w) begin
		if (armed && sck_w === pol) begin
			prx   = {prx[6:0], sdo_w};
			nedge = nedge + 1;
			armed = (nedge < 8);
		end else if (armed && nedge > 0) begin
			sdi_m = ptx[7 - nedge];
		end
	end

	// hold time over: line no longer shows the last bit
	always @(negedge armed) begin
		#200 sdi_m = ~sdi_m;
	end

	// ==========================================
	// master role, 320 ns link clock
	// clock stands at the idle level between frames
	task automatic idle(input logic p);
		sck_m = p;
	endtask : idle

	// select goes high after every frame, partial ones too
	task automatic xfer(input logic p, input logic [7:0] b, input int n);
		#7 ss_n_m = 1'b0;
		#320;
		for (int i = 0; i < n; i++) begin
			sck_m = ~p;
			sdi_m = b[7 - i];
			#160 sck_m = p;
			#160;
		end
		sdi_m  = ~sdi_m;
		ss_n_m = 1'b1;
		#320;
	endtask : xfer
endmodule : ssp_spi_peer

/* File: testbench/sync_serial_port_control_tb.sv */
// self-checking bench of the serial port control block
`timescale 1ns/1ps
module sync_serial_port_control_tb
	import ssp_pkg::*;
;
	// ==========================================
	// signals
	logic       clk, arst_n, wr, rd;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic       sck_o, sck_oe, sdo_o, sdo_oe, scl_o, scl_oe;
	logic       spi_pins_own, i2c_pins_own, irq;
	logic       sck_m, sdi_m, ss_n_m, sck_w, sdo_w;
	int         err_count, n_compared;

	// one table row: control value, pin owners, optional master byte
	typedef struct {
		logic [7:0] c;
		logic [4:0] e; // spi own, i2c own, sck oe, scl oe, sdo oe
		logic       x;
		logic [7:0] tx;
		logic [7:0] ptx;
	} ssp_row_t;
	ssp_row_t rows [17] = '{
		'{8'h20, 5'h15, 1'b1, 8'h69, 8'h00}, '{8'h21, 5'h15, 1'b1, 8'ha5, 8'h3c},
		'{8'h31, 5'h15, 1'b1, 8'h5a, 8'hc6}, '{8'h22, 5'h15, 1'b1, 8'h81, 8'h7e},
		'{8'h33, 5'h15, 1'b1, 8'he7, 8'h18}, '{8'h24, 5'h10, 1'b0, 8'h00, 8'h00},
		'{8'h25, 5'h11, 1'b0, 8'h00, 8'h00}, '{8'h26, 5'h0a, 1'b0, 8'h00, 8'h00},
		'{8'h36, 5'h08, 1'b0, 8'h00, 8'h00}, '{8'h27, 5'h0a, 1'b0, 8'h00, 8'h00},
		'{8'h2b, 5'h0a, 1'b0, 8'h00, 8'h00}, '{8'h3e, 5'h08, 1'b0, 8'h00, 8'h00},
		'{8'h2f, 5'h0a, 1'b0, 8'h00, 8'h00}, '{8'h10, 5'h00, 1'b0, 8'h00, 8'h00},
		'{8'h06, 5'h00, 1'b0, 8'h00, 8'h00}, '{8'h28, 5'h00, 1'b0, 8'h00, 8'h00},
		'{8'h3d, 5'h00, 1'b0, 8'h00, 8'h00}};

	// the port wins the clock line only while it drives it
	assign sck_w = sck_oe ? sck_o : sck_m;
	// released data line shows the inverse, not a held value
	assign sdo_w = sdo_oe ? sdo_o : ~sdo_o;

	// ==========================================
	// instances
	ssp_ctrl dut_u (
		.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(sdi_m), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.ss_n_i(ss_n_m), .scl_o(scl_o), .scl_oe(scl_oe), .spi_pins_own(spi_pins_own),
		.i2c_pins_own(i2c_pins_own), .irq(irq));
	ssp_spi_peer peer_u (.sck_w(sck_w), .sdo_w(sdo_w), .sck_m(sck_m), .sdi_m(sdi_m), .ss_n_m(ss_n_m));

	// 25 MHz host clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================
	// tasks
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string nm);
		logic [7:0] v;
		rd_reg(a, v);
		chk(nm, exp, v);
	endtask : rd_chk

	// poll a status bit, bounded
	task automatic wait_stat(input int b);
		logic [7:0] v;
		int         k;
		// the slowest master byte takes about two thousand cycles
		for (k = 0; k < 1500; k++) begin
			rd_reg(ADDR_STAT, v);
			if (v[b] === 1'b1)
				break;
		end
		if (k == 1500) begin
			$display("[FAIL] status wait expected bit %0d seen %h", b, v);
			err_count++;
			conclude();
		end
	endtask : wait_stat

	task automatic rst_chk();
		rd_chk(ADDR_CTRL, {4'h0, MODE_RESET}, "ctrl reset");
		rd_chk(ADDR_STAT, {6'h00, ST_RESET}, "status reset");
		rd_chk(ADDR_MASK, {6'h00, ST_RESET}, "mask reset");
		rd_chk(ADDR_DATA, DATA_RESET, "data reset");
	endtask : rst_chk

	// ==========================================
	// main sequence
	initial begin
		addr       = 4'h0;
		wdata      = 8'h00;
		wr         = 1'b0;
		rd         = 1'b0;
		arst_n     = 1'b0;
		err_count  = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rst_chk();
		// every named mode enabled plus two unused codes, two rows without enable, master bytes on five rows
		foreach (rows[i]) begin
			wr_reg(ADDR_CTRL, rows[i].c);
			rd_chk(ADDR_CTRL, rows[i].c, "ctrl");
			chk("pins", {3'h0, rows[i].e}, {3'h0, spi_pins_own, i2c_pins_own, sck_oe, scl_oe, sdo_oe});
			if (rows[i].c[5] && rows[i].c[3:2] == 2'b00)
				chk("sck idle", {7'h00, rows[i].c[4]}, {7'h00, sck_o});
			if (rows[i].x) begin
				wr_reg(ADDR_STAT, 8'h03);
				peer_u.arm(rows[i].ptx, rows[i].c[4]);
				wr_reg(ADDR_DATA, rows[i].tx);
				wait_stat(ST_RX);
				chk("peer rx", rows[i].tx, peer_u.prx);
				rd_chk(ADDR_STAT, 8'h01, "master no overflow");
			end
		end
		rd_chk(ADDR_DATA, 8'h18, "master rx");
		// interrupt masked, raised, cleared
		chk("irq masked", 8'h00, {7'h00, irq});
		wr_reg(ADDR_MASK, 8'h03);
		rd_chk(ADDR_MASK, 8'h03, "mask");
		chk("irq raised", 8'h01, {7'h00, irq});
		wr_reg(ADDR_STAT, 8'h00);
		rd_chk(ADDR_STAT, 8'h01, "status zero write");
		wr_reg(ADDR_STAT, 8'h01);
		rd_chk(ADDR_STAT, 8'h00, "status cleared");
		chk("irq cleared", 8'h00, {7'h00, irq});
		wr_reg(4'h4, 8'h5a);
		rd_chk(4'h4, 8'h00, "unmapped");
		// slave with select: half byte then select high, then a whole byte
		peer_u.idle(1'b1);
		wr_reg(ADDR_CTRL, 8'h34);
		peer_u.xfer(1'b1, 8'h3c, 4);
		peer_u.xfer(1'b1, 8'hc3, 8);
		wait_stat(ST_RX);
		rd_chk(ADDR_DATA, 8'hc3, "slave rx");
		// slave without select: second byte over an unread one
		peer_u.idle(1'b0);
		wr_reg(ADDR_CTRL, 8'h25);
		wr_reg(ADDR_STAT, 8'h03);
		// slave transmit: the armed peer drives the same bits as the frame
		wr_reg(ADDR_DATA, 8'hd2);
		peer_u.arm(8'h5a, 1'b0);
		peer_u.xfer(1'b0, 8'h5a, 8);
		chk("slave tx", 8'hd2, peer_u.prx);
		peer_u.xfer(1'b0, 8'h96, 8);
		wait_stat(ST_OVF);
		rd_chk(ADDR_CTRL, 8'h65, "overflow flag");
		rd_chk(ADDR_DATA, 8'h5a, "first byte kept");
		chk("irq overflow", 8'h01, {7'h00, irq});
		wr_reg(ADDR_CTRL, 8'h25);
		rd_chk(ADDR_CTRL, 8'h25, "overflow cleared");
		// reset in mid-run with the i2c clock held
		wr_reg(ADDR_CTRL, 8'h26);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset outputs", 8'h00, {4'h0, i2c_pins_own, scl_oe, scl_o, irq});
		arst_n <= 1'b1;
		rst_chk();
		conclude();
	end
endmodule : sync_serial_port_control_tb
